// ==== src/smp_link.sv ====
// Purpose: link-side shifter clocked by the serial clock
// Assumes: serial clock idles low, mode-0 framing
// Notes: frame counter cleared while the device is out of programming reset
`timescale 1ns/1ps
module smp_link (
  input wire logic sck_i,                   // serial clock from programmer
  input wire logic link_rst_i,              // async clear, reset pin high
  input wire logic mosi_i,                  // serial data in
  output logic miso_o,                      // serial data out
  input wire smp_pkg::smp_reply_t reply_i,  // reply byte, stable by the fall that starts byte 4
  output smp_pkg::smp_instr_t instr_o,      // last full instruction
  output logic done_tgl_o                   // toggles per received instruction
);
  logic [4:0] bit_cnt_r;
  logic [31:0] shift_r;
  logic [7:0] out_r;
  logic [4:0] bit_cnt_nxt;

  assign bit_cnt_nxt = bit_cnt_r + 5'h01;

  always_ff @(posedge sck_i or posedge link_rst_i) begin
    if (link_rst_i) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 32'h0000_0000;
      instr_o <= '0;
      done_tgl_o <= 1'b0;
    end else begin
      shift_r <= {shift_r[30:0], mosi_i};
      bit_cnt_r <= bit_cnt_nxt;
      if (bit_cnt_r == 5'h1f) begin
        instr_o <= {shift_r[30:0], mosi_i};
        done_tgl_o <= ~done_tgl_o;
      end
    end
  end

  // output shifts on the falling edge, loads at byte boundaries
  always_ff @(negedge sck_i or posedge link_rst_i) begin
    if (link_rst_i) begin
      out_r <= 8'h00;
    end else if (bit_cnt_r[2:0] == 3'h0) begin
      if (bit_cnt_r == 5'h10) begin
        out_r <= shift_r[7:0];
      end else if (bit_cnt_r == 5'h18 && reply_i.valid) begin
        out_r <= reply_i.data;
      end else begin
        out_r <= 8'h00;
      end
    end else begin
      out_r <= {out_r[6:0], 1'b0};
    end
  end

  // loaded on the fall before a byte, so bit 7 stands before its first rise
  assign miso_o = out_r[7];
endmodule : smp_link

// ==== src/smp_pkg.sv ====
// Purpose: shared constants and types for the serial memory programming port
// Assumes: four-byte instructions, msb first
// Notes: wait times are held in tenths of a millisecond, cycle counts derived in the top
package smp_pkg;
  localparam int CLK_MHZ = 125;
  localparam int FLASH_WORDS = 512;
  localparam int EE_BYTES = 64;
  localparam int FLASH_PAGE_WORDS = 16;
  localparam int EE_PAGE_BYTES = 4;
  localparam int FLASH_WAIT_US10 = 45;
  localparam int EE_WAIT_US10 = 40;
  localparam int ERASE_WAIT_US10 = 40;
  localparam logic [7:0] OP_PROG_EN = 8'hac;
  localparam logic [7:0] PROG_EN_B2 = 8'h53;
  localparam logic [2:0] B2_ERASE = 3'h4;
  localparam logic [2:0] B2_LOCK_WR = 3'h7;
  localparam logic [7:0] OP_RD_FLASH = 8'h20;
  localparam logic [7:0] OP_LD_FLASH = 8'h40;
  localparam logic [7:0] OP_WR_FLASH = 8'h4c;
  localparam logic [7:0] OP_RD_EE = 8'ha0;
  localparam logic [7:0] OP_WR_EE = 8'hc0;
  localparam logic [7:0] OP_LD_EE_PG = 8'hc1;
  localparam logic [7:0] OP_WR_EE_PG = 8'hc2;
  localparam logic [7:0] OP_RD_LOCK = 8'h58;
  localparam logic [7:0] OP_POLL = 8'hf0;
  localparam logic [7:0] HIBYTE_SEL = 8'h08;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [5:0] LOCK_RESET = 6'h3f;
  localparam logic [1:0] LOCK_PAD = 2'h3;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } smp_instr_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } smp_reply_t;
endpackage : smp_pkg

// ==== src/smp_port.sv ====
// Purpose: serial programming command interpreter with flash and eeprom arrays
// Assumes: reset pin synchronised here, serial clock is its own domain
// Notes: arrays modelled as registers; write times counted on clk_i
`timescale 1ns/1ps
module smp_port #(
  parameter int FLASH_WAIT_CYC = smp_pkg::FLASH_WAIT_US10 * smp_pkg::CLK_MHZ * 100,
  parameter int EE_WAIT_CYC = smp_pkg::EE_WAIT_US10 * smp_pkg::CLK_MHZ * 100,
  parameter int ERASE_WAIT_CYC = smp_pkg::ERASE_WAIT_US10 * smp_pkg::CLK_MHZ * 100
) (
  input wire logic clk_i,            // cpu clock, 125 MHz
  input wire logic rst_i,            // async power-on reset, active high
  input wire logic reset_n_i,        // device reset pin, low selects programming
  input wire logic sck_i,            // serial clock from programmer
  input wire logic mosi_i,           // serial data in
  output logic miso_o,               // serial data out
  output logic prog_enabled_o,       // programming enable accepted
  output logic busy_o,               // busy_poll_flag, write in progress
  output logic [5:0] lock_bits_o     // lock bits, zero means programmed
);
  localparam int CW = 24;

  // refuse waits that the timer cannot count
  if (FLASH_WAIT_CYC < 1 || FLASH_WAIT_CYC >= (1 << CW)) begin : g_bad_flash_wait
    $error("bad flash wait");
  end
  if (EE_WAIT_CYC < 1 || EE_WAIT_CYC >= (1 << CW)) begin : g_bad_ee_wait
    $error("bad eeprom wait");
  end
  if (ERASE_WAIT_CYC < 1 || ERASE_WAIT_CYC >= (1 << CW)) begin : g_bad_erase_wait
    $error("bad erase wait");
  end

  typedef enum logic [2:0] {
    SMP_IDLE, SMP_WR_FLASH, SMP_WR_EE, SMP_WR_EE_PG, SMP_ERASE, SMP_WAIT
  } smp_state_t;

  logic [1:0] rstn_sync_r;
  logic link_rst;
  smp_pkg::smp_instr_t instr_l;
  logic done_tgl_l;
  logic [2:0] done_sync_r;
  logic done_pulse;
  smp_pkg::smp_instr_t ins;
  smp_pkg::smp_reply_t reply_r;

  logic [7:0] flash_lo_r [smp_pkg::FLASH_WORDS];
  logic [7:0] flash_hi_r [smp_pkg::FLASH_WORDS];
  logic [7:0] ee_r [smp_pkg::EE_BYTES];
  logic [7:0] fbuf_lo_r [smp_pkg::FLASH_PAGE_WORDS];
  logic [7:0] fbuf_hi_r [smp_pkg::FLASH_PAGE_WORDS];
  logic [7:0] ebuf_r [smp_pkg::EE_PAGE_BYTES];
  logic [3:0] ebuf_ld_r;
  smp_state_t state_r;
  logic [CW-1:0] wait_r;
  logic [4:0] fpage_r;
  logic [3:0] epage_r;
  logic [5:0] eaddr_r;
  logic [7:0] edata_r;
  logic [8:0] rd_waddr;
  logic [5:0] rd_eaddr;
  logic prog_en_cmd;

  // reset pin held high keeps the link shifter cleared
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rstn_sync_r <= 2'b11;
    end else begin
      rstn_sync_r <= {rstn_sync_r[0], reset_n_i};
    end
  end
  assign link_rst = rst_i | rstn_sync_r[1];

  smp_link u_link (
    .sck_i(sck_i),
    .link_rst_i(link_rst),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .reply_i(reply_r),
    .instr_o(instr_l),
    .done_tgl_o(done_tgl_l)
  );

  // toggle crossing; instruction word is stable long after the toggle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_sync_r <= 3'h0;
    end else begin
      done_sync_r <= {done_sync_r[1:0], done_tgl_l};
    end
  end
  assign done_pulse = (done_sync_r[2] ^ done_sync_r[1]) & ~rstn_sync_r[1];
  assign ins = instr_l;

  assign prog_en_cmd = ins.b1 == smp_pkg::OP_PROG_EN && ins.b2 == smp_pkg::PROG_EN_B2;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_enabled_o <= 1'b0;
    end else if (rstn_sync_r[1]) begin
      prog_enabled_o <= 1'b0;
    end else if (done_pulse && prog_en_cmd) begin
      prog_enabled_o <= 1'b1;
    end
  end

  // answer built when an instruction lands, so it rides out on the next one;
  // changing only then keeps the word still while the link clock loads it
  assign rd_waddr = {ins.b2[0], ins.b3};
  assign rd_eaddr = ins.b3[5:0];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reply_r <= '0;
    end else if (!prog_enabled_o) begin
      reply_r <= '0;
    end else if (!done_pulse) begin
      reply_r <= reply_r;
    end else if (ins.b1 == smp_pkg::OP_POLL) begin
      reply_r <= '{data: {7'h00, busy_o}, valid: 1'b1};
    end else if (ins.b1 == smp_pkg::OP_RD_LOCK) begin
      reply_r <= '{data: {smp_pkg::LOCK_PAD, lock_bits_o}, valid: 1'b1};
    end else if (ins.b1 == smp_pkg::OP_RD_EE) begin
      reply_r <= '{data: ee_r[rd_eaddr], valid: 1'b1};
    end else if ((ins.b1 & ~smp_pkg::HIBYTE_SEL) == smp_pkg::OP_RD_FLASH) begin
      reply_r <= '{data: (ins.b1[3] ? flash_hi_r[rd_waddr] : flash_lo_r[rd_waddr]),
                   valid: 1'b1};
    end else begin
      reply_r <= '0;
    end
  end

  // command sequencer and write timer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= SMP_IDLE;
      wait_r <= '0;
      busy_o <= 1'b0;
      fpage_r <= 5'h00;
      epage_r <= 4'h0;
      eaddr_r <= 6'h00;
      edata_r <= 8'h00;
      lock_bits_o <= smp_pkg::LOCK_RESET;
    end else begin
      case (state_r)
        SMP_IDLE: begin
          if (done_pulse && prog_enabled_o) begin
            if (ins.b1 == smp_pkg::OP_WR_FLASH) begin
              fpage_r <= {ins.b2[0], ins.b3[7:4]};
              state_r <= SMP_WR_FLASH;
            end else if (ins.b1 == smp_pkg::OP_WR_EE) begin
              eaddr_r <= ins.b3[5:0];
              edata_r <= ins.b4;
              state_r <= SMP_WR_EE;
            end else if (ins.b1 == smp_pkg::OP_WR_EE_PG) begin
              epage_r <= ins.b3[5:2];
              state_r <= SMP_WR_EE_PG;
            end else if (ins.b1 == smp_pkg::OP_PROG_EN && ins.b2[7:5] == smp_pkg::B2_ERASE) begin
              state_r <= SMP_ERASE;
            end else if (ins.b1 == smp_pkg::OP_PROG_EN
                         && ins.b2[7:5] == smp_pkg::B2_LOCK_WR) begin
              lock_bits_o <= lock_bits_o & ins.b4[5:0];
            end
          end
        end
        SMP_WR_FLASH: begin
          wait_r <= CW'(FLASH_WAIT_CYC - 1);
          busy_o <= 1'b1;
          state_r <= SMP_WAIT;
        end
        SMP_WR_EE, SMP_WR_EE_PG: begin
          wait_r <= CW'(EE_WAIT_CYC - 1);
          busy_o <= 1'b1;
          state_r <= SMP_WAIT;
        end
        SMP_ERASE: begin
          wait_r <= CW'(ERASE_WAIT_CYC - 1);
          busy_o <= 1'b1;
          lock_bits_o <= smp_pkg::LOCK_RESET;
          state_r <= SMP_WAIT;
        end
        SMP_WAIT: begin
          if (wait_r == '0) begin
            busy_o <= 1'b0;
            state_r <= SMP_IDLE;
          end else begin
            wait_r <= wait_r - CW'(1);
          end
        end
        default: state_r <= SMP_IDLE;
      endcase
    end
  end

  // page buffers
  always_ff @(posedge clk_i) begin
    if (done_pulse && prog_enabled_o && state_r == SMP_IDLE
        && (ins.b1 & ~smp_pkg::HIBYTE_SEL) == smp_pkg::OP_LD_FLASH
        && ins.b1 != smp_pkg::OP_WR_FLASH) begin
      if (ins.b1[3]) begin
        fbuf_hi_r[ins.b3[3:0]] <= ins.b4;
      end else begin
        fbuf_lo_r[ins.b3[3:0]] <= ins.b4;
      end
    end
    if (done_pulse && prog_enabled_o && state_r == SMP_IDLE
        && ins.b1 == smp_pkg::OP_LD_EE_PG) begin
      ebuf_r[ins.b3[1:0]] <= ins.b4;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ebuf_ld_r <= 4'h0;
    end else if (state_r == SMP_WR_EE_PG) begin
      ebuf_ld_r <= 4'h0;
    end else if (done_pulse && prog_enabled_o && state_r == SMP_IDLE
                 && ins.b1 == smp_pkg::OP_LD_EE_PG) begin
      ebuf_ld_r[ins.b3[1:0]] <= 1'b1;
    end
  end

  // arrays, committed when the timed operation starts
  always_ff @(posedge clk_i) begin
    if (state_r == SMP_ERASE) begin
      for (int i = 0; i < smp_pkg::FLASH_WORDS; i++) begin
        flash_lo_r[i] <= smp_pkg::ERASED;
        flash_hi_r[i] <= smp_pkg::ERASED;
      end
      for (int i = 0; i < smp_pkg::EE_BYTES; i++) begin
        ee_r[i] <= smp_pkg::ERASED;
      end
    end else if (state_r == SMP_WR_FLASH) begin
      for (int i = 0; i < smp_pkg::FLASH_PAGE_WORDS; i++) begin
        flash_lo_r[{fpage_r, 4'(i)}] <= fbuf_lo_r[i];
        flash_hi_r[{fpage_r, 4'(i)}] <= fbuf_hi_r[i];
      end
    end else if (state_r == SMP_WR_EE) begin
      ee_r[eaddr_r] <= edata_r;
    end else if (state_r == SMP_WR_EE_PG) begin
      for (int i = 0; i < smp_pkg::EE_PAGE_BYTES; i++) begin
        if (ebuf_ld_r[i]) begin
          ee_r[{epage_r, 2'(i)}] <= ebuf_r[i];
        end
      end
    end
  end
endmodule : smp_port

// ==== tb/smp_port_monitor.sv ====
// Purpose: port checks of the serial programming block
// Assumes: wait parameters equal those of the instance
// Notes: sampled on the cpu clock only
`timescale 1ns/1ps
module smp_port_monitor #(
  parameter int FLASH_WAIT_CYC = 20,
  parameter int EE_WAIT_CYC = 20,
  parameter int ERASE_WAIT_CYC = 20
) (
  input wire logic clk_i,             // cpu clock
  input wire logic rst_i,             // power-on reset
  input wire logic reset_n_i,         // device reset pin
  input wire logic sck_i,             // serial clock
  input wire logic miso_o,            // serial data out
  input wire logic prog_enabled_o,    // enable accepted
  input wire logic busy_o,            // write running
  input wire logic [5:0] lock_bits_o  // lock bits
);
  localparam int MIN_WAIT = EE_WAIT_CYC < ERASE_WAIT_CYC ? EE_WAIT_CYC : ERASE_WAIT_CYC;
  int bcnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) bcnt <= 0;
    else if (busy_o) bcnt <= bcnt + 1;
    else bcnt <= 0;
  end
  chk_rst_quiet: assert property ($fell(rst_i) |->
    !prog_enabled_o && !busy_o && lock_bits_o == 6'h3f) else $error("not idle after reset");
  chk_busy_needs_en: assert property ($rose(busy_o) |-> prog_enabled_o)
    else $error("write started without enable");
  chk_lock_needs_en: assert property ($changed(lock_bits_o) |-> $past(prog_enabled_o))
    else $error("lock bits changed without enable");
  chk_lock_clear_only: assert property ($changed(lock_bits_o) |->
    (lock_bits_o & ~$past(lock_bits_o)) == 6'h00 || lock_bits_o == 6'h3f)
    else $error("lock bit unprogrammed by write");
  chk_busy_min_len: assert property ($fell(busy_o) |-> bcnt >= MIN_WAIT - 1)
    else $error("busy too short");
  chk_busy_max_len: assert property (bcnt <= FLASH_WAIT_CYC + 2)
    else $error("busy too long");
  chk_session_end: assert property ($rose(reset_n_i) |-> ##[1:6] !prog_enabled_o)
    else $error("enable kept after reset pin high");
  chk_en_in_session: assert property ($rose(prog_enabled_o) |-> !reset_n_i)
    else $error("enable outside session");
  chk_miso_on_fall: assert property ($changed(miso_o) |-> !sck_i)
    else $error("serial out moved with clock high");
  cov_enable: cover property ($rose(prog_enabled_o));
  cov_busy: cover property ($fell(busy_o));
  cov_lock: cover property ($changed(lock_bits_o));
endmodule : smp_port_monitor

bind smp_port smp_port_monitor #(.FLASH_WAIT_CYC(FLASH_WAIT_CYC), .EE_WAIT_CYC(EE_WAIT_CYC),
  .ERASE_WAIT_CYC(ERASE_WAIT_CYC)) i_mon (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
  .sck_i(sck_i), .miso_o(miso_o), .prog_enabled_o(prog_enabled_o), .busy_o(busy_o),
  .lock_bits_o(lock_bits_o));

// ==== tb/smp_port_tb_top.sv ====
// Purpose: self-checking bench for the serial programming block
// Assumes: write waits shortened to 300 cycles
// Notes: replies lag one instruction, so reads and polls go twice
`timescale 1ns/1ps
module smp_port_tb_top;
  // long enough that a poll sent right after a write lands while busy
  localparam int WAIT = 300;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_n_i = 1'b1;
  logic sck, mosi, miso, en, busy;
  logic [5:0] lock, a, ld;
  logic [3:0] p;
  logic [8:0] fw;
  logic [7:0] v;
  logic [31:0] r;
  int n_fail = 0;
  int checked = 0;
  int seed = 49667;
  int cyc = 0;

  always #4 clk_i = ~clk_i;

  smp_port #(.FLASH_WAIT_CYC(WAIT), .EE_WAIT_CYC(WAIT), .ERASE_WAIT_CYC(WAIT)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .sck_i(sck), .mosi_i(mosi),
    .miso_o(miso), .prog_enabled_o(en), .busy_o(busy), .lock_bits_o(lock));
  smp_prog_model i_prog (.sck_o(sck), .mosi_o(mosi), .miso_i(miso));

  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : cmp

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic op(input logic [31:0] w);
    i_prog.xfer(w, r);
    repeat (8) @(posedge clk_i);
    #1;
  endtask : op

  // polls the port flag instead of timing the documented waits
  task automatic idle;
    for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk_i);
    #1;
    cmp(busy, 1'b0);
  endtask : idle

  // the reply belongs to the previous frame, so every read goes twice
  task automatic rchk(input logic [31:0] w, input logic [7:0] e);
    op(w);
    op(w);
    cmp(r[7:0], e);
  endtask : rchk

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    reset_n_i = 1'b0;
    // the 20 ms settle is scaled down to keep the run short
    repeat (40) @(posedge clk_i);
    #1;
    op(32'hac80_0000);
    op(32'hace0_00c0);
    cmp(busy, 1'b0);
    cmp(lock, 6'h3f);
    op(32'hac53_0000);
    cmp(r[15:8], 8'h53);
    cmp(en, 1'b1);
    op(32'hac80_0000);
    cmp(busy, 1'b1);
    idle();
    rchk(32'h2801_ff00, 8'hff);
    rchk(32'ha000_3f00, 8'hff);
    a = 6'($random(seed));
    v = 8'($random(seed));
    repeat (2) begin
      op({8'hc0, 8'h00, 2'b00, a, v});
      // first poll lands mid-write, the second one carries its answer
      op(32'hf000_0000);
      op(32'hf000_0000);
      cmp(r[7:0], 8'h01);
      rchk(32'hf000_0000, 8'h00);
      idle();
      rchk({8'ha0, 8'h00, 2'b00, a, 8'h00}, v);
      v = ~v;
    end
    p = ~a[5:2];
    op({8'hc0, 8'h00, 2'b00, p, 2'd1, 8'h5a});
    idle();
    op({8'hc1, 8'h00, 8'h00, v});
    op({8'hc1, 8'h00, 8'h02, ~v});
    op({8'hc2, 8'h00, 2'b00, p, 2'b00, 8'h00});
    idle();
    rchk({8'ha0, 8'h00, 2'b00, p, 2'd0, 8'h00}, v);
    rchk({8'ha0, 8'h00, 2'b00, p, 2'd1, 8'h00}, 8'h5a);
    rchk({8'ha0, 8'h00, 2'b00, p, 2'd2, 8'h00}, ~v);
    rchk({8'ha0, 8'h00, 2'b00, p, 2'd3, 8'h00}, 8'hff);
    fw = 9'($random(seed));
    op({8'h40, 8'h00, 4'h0, fw[3:0], v});
    op({8'h48, 8'h00, 4'h0, fw[3:0], ~v});
    op({8'h4c, 7'h00, fw[8], fw[7:4], 4'h0, 8'h00});
    idle();
    rchk({8'h20, 7'h00, fw[8], fw[7:0], 8'h00}, v);
    rchk({8'h28, 7'h00, fw[8], fw[7:0], 8'h00}, ~v);
    ld = 6'($random(seed));
    op({8'hac, 8'he0, 8'h00, 2'b11, ld});
    idle();
    cmp(lock, ld);
    rchk(32'h5800_0000, {2'b11, ld});
    @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    cmp(en, 1'b0);
    reset_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    op(32'hac80_0000);
    cmp(busy, 1'b0);
    tally_and_finish();
  end
endmodule : smp_port_tb_top

// ==== tb/smp_prog_model.sv ====
// Purpose: programmer model driving the serial programming link
// Assumes: mode-0 framing, 48 ns serial clock period
// Notes: clock stands low between frames
`timescale 1ns/1ps
module smp_prog_model (
  output logic sck_o,      // serial clock to device
  output logic mosi_o,     // serial data to device
  input wire logic miso_i  // serial data from device
);
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end

  // 24 ns phases are three cpu cycles, the floor above 12 MHz
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    #3.3;
    for (int i = 31; i >= 0; i--) begin
      mosi_o = w[i];
      #24;
      r[i] = miso_i;
      sck_o = 1'b1;
      #24;
      sck_o = 1'b0;
    end
    // no pull on this line, so never leave the last bit standing
    mosi_o = ~w[0];
  endtask : xfer
endmodule : smp_prog_model
